// *** hw/strobe_pkg.sv ***
// constants, field layouts and state types shared by the strobe generator
package strobe_pkg;
    // clock and microsecond step
    localparam int CLK_PERIOD_PS = 5000;       // core clock period, 200 MHz
    localparam int STEP_US_PS    = 1000000;    // one strobe timing step, 1 us
    localparam int CYC_PER_US    = STEP_US_PS / CLK_PERIOD_PS;
    localparam int DIV_W         = $clog2(CYC_PER_US);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CYC_PER_US - 1);

    // timing value width (0 .. 16777215 us)
    localparam int TW = 24;
    localparam logic [TW-1:0] T_MAX = {TW{1'b1}};

    // register byte offsets
    localparam logic [7:0] OFF_CTRL      = 8'h00;
    localparam logic [7:0] OFF_TRG_DELAY = 8'h04;
    localparam logic [7:0] OFF_TRG_DUR   = 8'h08;
    localparam logic [7:0] OFF_STATUS    = 8'h0c;
    localparam logic [7:0] OFF_CH_BASE   = 8'h10;
    localparam logic [7:0] OFF_CH_STRIDE = 8'h10;
    localparam logic [7:0] OFF_CH_MODE   = 8'h00;
    localparam logic [7:0] OFF_CH_POS    = 8'h04;
    localparam logic [7:0] OFF_CH_DUR    = 8'h08;

    // field positions
    localparam int CTRL_TRG_MODE = 0;          // camera in trigger mode
    localparam int MODE_EN       = 0;          // strobe enable
    localparam int MODE_SEL_LO   = 1;          // frame selection, 2 bits
    localparam int MODE_TRG      = 3;          // trigger strobe option
    localparam int MODE_W        = 4;
    localparam int STAT_ODD      = 2;          // parity bits start here

    // reset values
    localparam logic [MODE_W-1:0] MODE_RST = 4'h0;
    localparam logic [TW-1:0]     POS_RST  = 24'h000001;
    localparam logic [TW-1:0]     DUR_RST  = 24'h000001;
    localparam logic [TW-1:0]     TRG_RST  = 24'h000000;

    // frame selection codes
    localparam logic [1:0] SEL_EACH = 2'h0;
    localparam logic [1:0] SEL_ODD  = 2'h1;
    localparam logic [1:0] SEL_EVEN = 2'h2;

    // trigger strobe sequencer, gray coded along idle-delay-pulse
    typedef enum logic [1:0] {
        TRG_IDLE  = 2'b00,
        TRG_DELAY = 2'b01,
        TRG_PULSE = 2'b11
    } trg_state_e;
endpackage : strobe_pkg

// *** hw/strobe_channel.sv ***
// one strobe output: frame strobe with parity select plus trigger strobe
`timescale 1ns/1ps
module strobe_channel
    import strobe_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              us_tick,
    input  wire logic              frame_start,
    input  wire logic              trig_rise,
    input  wire logic              trig_mode,
    input  wire logic [MODE_W-1:0] mode,
    input  wire logic [TW-1:0]     position,
    input  wire logic [TW-1:0]     duration,
    input  wire logic [TW-1:0]     trig_delay,
    input  wire logic [TW-1:0]     trig_dur,
    output logic                   strobe,
    output logic                   frame_odd
);
    logic          enable;          // strobe enabled
    logic          trig_en;         // trigger strobe option
    logic [1:0]    sel;             // frame selection
    logic          next_odd;        // parity of the coming frame
    logic          armed;           // this frame is selected
    logic [TW-1:0] fcnt;            // us since frame start
    logic          frame_hit;       // frame pulse window active
    trg_state_e    tstate;          // trigger sequencer state
    logic [TW-1:0] tcnt;            // us counter for trigger delay/width
    logic          trig_go;         // accepted trigger edge

    assign enable  = mode[MODE_EN];
    assign trig_en = mode[MODE_TRG];
    assign sel     = mode[MODE_SEL_LO +: 2];
    assign trig_go = trig_rise & trig_mode & trig_en & enable;

    // frame parity, first frame after enable is odd
    always_ff @(posedge clk) begin
        if (rst || !enable) begin
            next_odd  <= 1'b1;
            frame_odd <= 1'b0;
        end else if (frame_start) begin
            next_odd  <= ~next_odd;
            frame_odd <= next_odd;
        end
    end

    // frame selection decides at each frame start
    always_ff @(posedge clk) begin
        if (rst || !enable) begin
            armed <= 1'b0;
        end else if (frame_start) begin
            armed <= (sel == SEL_EACH) ||
                     (sel == SEL_ODD && next_odd) ||
                     (sel == SEL_EVEN && !next_odd);
        end
    end

    // microsecond position counter, saturating
    always_ff @(posedge clk) begin
        if (rst || frame_start) begin
            fcnt <= '0;
        end else if (us_tick && fcnt != T_MAX) begin
            fcnt <= fcnt + 1'b1;
        end
    end

    // frame pulse window, cut at the frame end
    always_ff @(posedge clk) begin
        if (rst || !enable || frame_start) begin
            frame_hit <= 1'b0;
        end else begin
            frame_hit <= armed && (fcnt >= position) &&
                         ({1'b0, fcnt} < ({1'b0, position} + {1'b0, duration}));
        end
    end

    // trigger strobe sequencer
    always_ff @(posedge clk) begin
        if (rst || !enable) begin
            tstate <= TRG_IDLE;
            tcnt   <= '0;
        end else begin
            case (tstate)
                TRG_IDLE: begin
                    tcnt <= '0;
                    if (trig_go) begin
                        tstate <= TRG_DELAY;
                    end
                end
                TRG_DELAY: begin
                    // delay reached: start the pulse with a fresh count, or go back to idle when the width is zero
                    if (tcnt >= trig_delay) begin
                        tcnt   <= '0;
                        tstate <= (trig_dur == '0) ? TRG_IDLE : TRG_PULSE;
                    end else if (us_tick) begin
                        tcnt <= tcnt + 1'b1;
                    end
                end
                TRG_PULSE: begin
                    // width reached: back to idle
                    if (tcnt >= trig_dur) begin
                        tstate <= TRG_IDLE;
                        tcnt   <= '0;
                    end else if (us_tick) begin
                        tcnt <= tcnt + 1'b1;
                    end
                end
                default: begin
                    tstate <= TRG_IDLE;
                    tcnt   <= '0;
                end
            endcase
        end
    end

    // output flop
    always_ff @(posedge clk) begin
        if (rst) begin
            strobe <= 1'b0;
        end else begin
            strobe <= enable && (frame_hit || tstate == TRG_PULSE);
        end
    end

    AST_DISABLED_QUIET: assert property (
        @(posedge clk) disable iff (rst) !enable |=> !strobe)
        else $error("disabled strobe output went active");

    AST_PARITY_START: assert property (
        @(posedge clk) disable iff (rst) $rose(enable) |-> next_odd && !armed)
        else $error("parity did not restart at odd on enable");

    AST_EVEN_SKIPS_ODD: assert property (
        @(posedge clk) disable iff (rst)
        enable && frame_start && sel == SEL_EVEN && next_odd |=> !armed)
        else $error("even-only strobe armed on an odd frame");

    AST_POS_WINDOW: assert property (
        @(posedge clk) disable iff (rst)
        frame_hit |-> $past(fcnt) >= $past(position) && $past(armed))
        else $error("frame strobe began before its position");

    AST_WIDTH_WINDOW: assert property (
        @(posedge clk) disable iff (rst)
        frame_hit |-> {1'b0, $past(fcnt)} < {1'b0, $past(position)} + {1'b0, $past(duration)})
        else $error("frame strobe outlasted its duration");

    AST_FRAME_CUT: assert property (
        @(posedge clk) disable iff (rst) frame_start |=> !frame_hit)
        else $error("frame strobe ran past the frame end");

    AST_TRIG_ACCEPT: assert property (
        @(posedge clk) disable iff (rst)
        tstate == TRG_IDLE && trig_go |=> tstate == TRG_DELAY)
        else $error("trigger edge not taken");

    AST_TRIG_IGNORE: assert property (
        @(posedge clk) disable iff (rst)
        tstate == TRG_IDLE && !trig_go |=> tstate == TRG_IDLE)
        else $error("trigger strobe started without a trigger");

    AST_DELAY_HOLD: assert property (
        @(posedge clk) disable iff (rst)
        tstate == TRG_DELAY && tcnt < trig_delay && enable |=> tstate == TRG_DELAY)
        else $error("trigger delay ended early");
endmodule : strobe_channel

// *** hw/strobe_gen.sv ***
// dual strobe pulse generator with APB register access
`timescale 1ns/1ps
// Overview of operation
// - two strobes, each with its own mode, position and width; trigger mode and timing shared
// - disabled strobe stays permanently inactive
// - fire on each, odd or even frames
// - trigger mode adds pulse per trigger rise
// - frame pulse starts at programmable position
// - frame pulse width programmable per strobe
// - position and width counted in 1 us
// - trigger pulse delay and width, 24-bit us
module strobe_gen
    import strobe_pkg::*;
(
    input  wire logic        CORE_CLK,
    input  wire logic        RST,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        FRAME_START,
    input  wire logic        TRIGGER,
    output logic      [1:0]  STROBE
);
    localparam int NCH = 2;                 // number of strobe outputs

    logic [DIV_W-1:0]  div;                 // cycle divider for us step
    logic              us_tick;             // one-cycle pulse per us
    logic              trig_d;              // trigger level, previous cycle
    logic              trig_rise;           // trigger rising edge
    logic              trig_mode;           // camera in trigger mode
    logic [TW-1:0]     trig_delay;          // trigger strobe delay, us
    logic [TW-1:0]     trig_dur;            // trigger strobe width, us
    logic [MODE_W-1:0] mode [NCH];          // per strobe mode
    logic [TW-1:0]     position [NCH];      // per strobe position, us
    logic [TW-1:0]     duration [NCH];      // per strobe width, us
    logic [NCH-1:0]    odd;                 // current frame parity
    logic [NCH-1:0]    sel_mode;            // mode register decoded
    logic [NCH-1:0]    sel_pos;             // position register decoded
    logic [NCH-1:0]    sel_dur;             // width register decoded
    logic              wr_go;               // write takes effect
    logic              setup;               // apb setup cycle
    logic [31:0]       next_rdata;          // read value being selected
    logic              next_err;            // address unmapped

    // microsecond step generator, restarted by every frame start
    always_ff @(posedge CORE_CLK) begin
        if (RST || FRAME_START) begin
            // the step phase follows the frame, so a position lands on its exact us
            div     <= '0;
            us_tick <= 1'b0;
        end else begin
            us_tick <= (div == DIV_LAST);
            div     <= (div == DIV_LAST) ? '0 : div + 1'b1;
        end
    end

    // trigger edge detect, same clock domain as the pixel timing
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            trig_d <= 1'b0;
        end else begin
            trig_d <= TRIGGER;
        end
    end
    assign trig_rise = TRIGGER & ~trig_d;

    // apb phases
    assign setup = PSEL & ~PENABLE;
    assign wr_go = PSEL & PENABLE & PREADY & PWRITE;

    // apb handshake: ready in the first access cycle
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
        end else begin
            PREADY  <= setup;
            PSLVERR <= setup & next_err;
        end
    end

    // read data registered at the setup cycle
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            PRDATA <= '0;
        end else if (setup && !PWRITE) begin
            PRDATA <= next_rdata;
        end
    end

    // shared registers: trigger mode and trigger strobe timing
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            trig_mode  <= 1'b0;
            trig_delay <= TRG_RST;
            trig_dur   <= TRG_RST;
        end else if (wr_go) begin
            if (PADDR == OFF_CTRL) begin
                trig_mode <= PWDATA[CTRL_TRG_MODE];
            end
            if (PADDR == OFF_TRG_DELAY) begin
                trig_delay <= PWDATA[TW-1:0];
            end
            if (PADDR == OFF_TRG_DUR) begin
                trig_dur <= PWDATA[TW-1:0];
            end
        end
    end

    // per strobe registers and channel logic
    for (genvar i = 0; i < NCH; i++) begin : g_ch
        localparam logic [7:0] BASE = 8'(OFF_CH_BASE + i * OFF_CH_STRIDE);

        // address decode for this strobe only
        assign sel_mode[i] = (PADDR == 8'(BASE + OFF_CH_MODE));
        assign sel_pos[i]  = (PADDR == 8'(BASE + OFF_CH_POS));
        assign sel_dur[i]  = (PADDR == 8'(BASE + OFF_CH_DUR));

        // settings of this strobe
        always_ff @(posedge CORE_CLK) begin
            if (RST) begin
                mode[i]     <= MODE_RST;
                position[i] <= POS_RST;
                duration[i] <= DUR_RST;
            end else if (wr_go) begin
                if (sel_mode[i]) begin
                    mode[i] <= PWDATA[MODE_W-1:0];
                end
                if (sel_pos[i]) begin
                    position[i] <= PWDATA[TW-1:0];
                end
                if (sel_dur[i]) begin
                    duration[i] <= PWDATA[TW-1:0];
                end
            end
        end

        strobe_channel u_ch (
            .clk         (CORE_CLK),
            .rst         (RST),
            .us_tick     (us_tick),
            .frame_start (FRAME_START),
            .trig_rise   (trig_rise),
            .trig_mode   (trig_mode),
            .mode        (mode[i]),
            .position    (position[i]),
            .duration    (duration[i]),
            .trig_delay  (trig_delay),
            .trig_dur    (trig_dur),
            .strobe      (STROBE[i]),
            .frame_odd   (odd[i])
        );
    end

    // read multiplexer and unmapped address detection
    always_comb begin
        next_rdata = '0;
        next_err   = 1'b0;
        if (PADDR == OFF_CTRL) begin
            next_rdata[CTRL_TRG_MODE] = trig_mode;
        end else if (PADDR == OFF_TRG_DELAY) begin
            next_rdata[TW-1:0] = trig_delay;
        end else if (PADDR == OFF_TRG_DUR) begin
            next_rdata[TW-1:0] = trig_dur;
        end else if (PADDR == OFF_STATUS) begin
            // live strobe levels and frame parity
            next_rdata[NCH-1:0]            = STROBE;
            next_rdata[STAT_ODD +: NCH]    = odd;
        end else if (sel_mode[0]) begin
            next_rdata[MODE_W-1:0] = mode[0];
        end else if (sel_pos[0]) begin
            next_rdata[TW-1:0] = position[0];
        end else if (sel_dur[0]) begin
            next_rdata[TW-1:0] = duration[0];
        end else if (sel_mode[1]) begin
            next_rdata[MODE_W-1:0] = mode[1];
        end else if (sel_pos[1]) begin
            next_rdata[TW-1:0] = position[1];
        end else if (sel_dur[1]) begin
            next_rdata[TW-1:0] = duration[1];
        end else begin
            // unmapped: reads zero with an error answer
            next_err = 1'b1;
        end
    end

    AST_TICK_SPACING: assert property (
        @(posedge CORE_CLK) disable iff (RST) us_tick |=> !us_tick [*8])
        else $error("microsecond step came too soon");

    AST_CH_ISOLATION: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        wr_go && sel_mode[0] |=> $stable(mode[1]) && $stable(position[1]))
        else $error("write to strobe 1 changed strobe 2");

    AST_READY_ONE: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        setup |=> PREADY ##1 !PREADY)
        else $error("apb ready not a single access cycle");

    AST_TICK_FRAME_ALIGN: assert property (
        @(posedge CORE_CLK) disable iff (RST) FRAME_START |=> !us_tick && div == '0)
        else $error("microsecond step not restarted at frame start");

    AST_DELAY_WRITE: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        wr_go && PADDR == OFF_TRG_DELAY |=> trig_delay == $past(PWDATA[TW-1:0]))
        else $error("trigger delay write did not land");

    AST_POS_WRITE: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        wr_go && sel_pos[1] |=> position[1] == $past(PWDATA[TW-1:0]))
        else $error("strobe 2 position write did not land");

    AST_DUR_ISOLATION: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        wr_go && sel_dur[1] |=> $stable(duration[0]) && $stable(position[0]))
        else $error("write to strobe 2 changed strobe 1");

    AST_STROBE_OFF: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        !mode[1][MODE_EN] |=> !STROBE[1])
        else $error("disabled strobe 2 went active");
endmodule : strobe_gen

// *** sim/strobe_lamp.sv ***
// behavioural strobe lamp that times each lit span against the latest mark
`timescale 1ns/1ps
module strobe_lamp (
    input  wire logic       clk,
    input  wire logic       frame_start,
    input  wire logic       trigger,
    input  wire logic [1:0] strobe,
    output int              rise_at [2],
    output int              width   [2],
    output int              pulses  [2]
);
    int         t;        // cycles since the last frame or trigger mark
    int         hi [2];   // length of the span in progress
    logic       trig_d;   // trigger one cycle ago
    logic [1:0] lit;      // lamp state one cycle ago

    // start dark with empty records
    initial begin
        t = 0;
        trig_d = 1'b0;
        lit = 2'h0;
        for (int i = 0; i < 2; i++) begin
            rise_at[i] = 0;
            width[i] = 0;
            pulses[i] = 0;
            hi[i] = 0;
        end
    end

    // a frame start or a trigger rise restarts the time base
    always @(posedge clk) begin
        trig_d <= trigger;
        lit <= strobe;
        t <= (frame_start || (trigger && !trig_d)) ? 0 : t + 1;
        for (int i = 0; i < 2; i++) begin
            // light on: note when and count it
            if (strobe[i] && !lit[i]) begin
                rise_at[i] <= t;
                pulses[i] <= pulses[i] + 1;
            end
            hi[i] <= strobe[i] ? hi[i] + 1 : 0;
            // light off: keep the span length
            if (!strobe[i] && lit[i]) begin
                width[i] <= hi[i];
            end
        end
    end
endmodule : strobe_lamp

// *** sim/dual_strobe_pulse_generator_tb.sv ***
// self-checking bench for the dual strobe generator
`timescale 1ns/1ps
module dual_strobe_pulse_generator_tb;
    import strobe_pkg::*;
    logic        CORE_CLK = 1'b0;  // 200 MHz core clock
    logic        RST = 1'b1;       // synchronous reset
    logic        PSEL = 1'b0;      // apb select
    logic        PENABLE = 1'b0;   // apb access phase
    logic        PWRITE = 1'b0;    // apb direction
    logic [7:0]  PADDR = 8'h00;    // apb byte address
    logic [31:0] PWDATA = 32'h0;   // apb write data
    logic [31:0] PRDATA;           // apb read data
    logic        PREADY;           // apb answer
    logic        PSLVERR;          // apb error
    logic        FRAME_START = 1'b0; // frame mark from pixel timing
    logic        TRIGGER = 1'b0;   // trigger level
    logic [1:0]  STROBE;           // strobe outputs
    int          rise_at [2];      // lamp records
    int          width [2];
    int          pulses [2];
    int          n_errors = 0;
    int          comparisons = 0;
    int          seed = 76;
    int          pos [2];          // random positions in us
    int          dur [2];          // random widths in us
    int          np;               // pulse count before a step
    int          d;                // trigger delay in us
    int          u;                // trigger width in us
    logic [31:0] rd;               // last read data
    logic        er;               // last error flag

    // free-running core clock
    always #2.5 CORE_CLK = ~CORE_CLK;

    strobe_gen dut (.CORE_CLK(CORE_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .FRAME_START(FRAME_START), .TRIGGER(TRIGGER), .STROBE(STROBE));

    strobe_lamp lamp (.clk(CORE_CLK), .frame_start(FRAME_START), .trigger(TRIGGER),
        .strobe(STROBE), .rise_at(rise_at), .width(width), .pulses(pulses));

    // byte address of a per-strobe register
    function automatic logic [7:0] ch_addr(int n, logic [7:0] off);
        return OFF_CH_BASE + 8'(n) * OFF_CH_STRIDE + off;
    endfunction : ch_addr

    // whether a selection code fires on frame f, frame 1 being odd
    function automatic bit fires(int sel, int f);
        return sel == 0 || (sel == 1 && f % 2 == 1) || (sel == 2 && f % 2 == 0);
    endfunction : fires

    // microseconds to core cycles
    function automatic int cyc(int us);
        return us * CYC_PER_US;
    endfunction : cyc

    // compare a register or port value exactly
    task chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask : chk_val

    // compare a lamp timing within a tolerance
    task chk_time(input int got, input int exp, input int tol, input string what);
        comparisons++;
        if (got < exp - tol || got > exp + tol) begin
            n_errors++;
            $display("Error at %0t: %s got %0d expected %0d", $time, what, got, exp);
        end
    endtask : chk_time

    // one apb transfer: setup, access held until pready, then release
    task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int k;
        k = 0;
        @(posedge CORE_CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= wd;
        @(posedge CORE_CLK);
        PENABLE <= 1'b1;
        // pready is looked at on rising edges; data and error are taken there
        do begin
            @(posedge CORE_CLK);
            k++;
        end while (PREADY !== 1'b1 && k < 50);
        if (k >= 50) chk_val(32'h0, 32'h1, "apb answer");
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask : apb

    // read a register and compare data and error flag
    task rchk(input logic [7:0] a, input logic [31:0] exp, input logic xer);
        apb(1'b0, a, 32'h0);
        chk_val(rd, exp, "read data");
        chk_val(32'(er), 32'(xer), "read error");
    endtask : rchk

    // one frame of ten microseconds, ending settled at a falling edge
    task frame();
        @(posedge CORE_CLK);
        FRAME_START <= 1'b1;
        @(posedge CORE_CLK);
        FRAME_START <= 1'b0;
        repeat (cyc(10) - 2) @(posedge CORE_CLK);
        @(negedge CORE_CLK);
    endtask : frame

    // trigger rise, then wait long enough for its pulse to finish
    task trig();
        @(posedge CORE_CLK);
        TRIGGER <= 1'b1;
        repeat (3) @(posedge CORE_CLK);
        TRIGGER <= 1'b0;
        repeat (cyc(d + u + 2)) @(posedge CORE_CLK);
        @(negedge CORE_CLK);
    endtask : trig

    // counts, verdict and end of run
    task report_and_stop();
        $display("comparisons %0d errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop

    // main sequence
    initial begin
        repeat (2) @(posedge CORE_CLK);
        RST <= 1'b0;
        @(negedge CORE_CLK);
        chk_val(32'(STROBE), 32'h0, "strobe after reset");
        // reset values, masking of upper bits, unmapped place
        for (int n = 0; n < 2; n++) begin
            rchk(ch_addr(n, OFF_CH_MODE), 32'(MODE_RST), 1'b0);
            rchk(ch_addr(n, OFF_CH_POS), 32'(POS_RST), 1'b0);
            rchk(ch_addr(n, OFF_CH_DUR), 32'(DUR_RST), 1'b0);
            pos[n] = 1 + ($random(seed) & 3);
            dur[n] = 1 + ($random(seed) & 3);
            apb(1'b1, ch_addr(n, OFF_CH_POS), {8'hff, 24'(pos[n])});
            apb(1'b1, ch_addr(n, OFF_CH_DUR), 32'(dur[n]));
            rchk(ch_addr(n, OFF_CH_POS), 32'(pos[n]), 1'b0);
        end
        rchk(OFF_TRG_DELAY, 32'(TRG_RST), 1'b0);
        apb(1'b1, OFF_TRG_DELAY, 32'hffffffff);
        rchk(OFF_TRG_DELAY, 32'(T_MAX), 1'b0);
        rchk(8'h40, 32'h0, 1'b1);
        $display("test registers done");
        // both strobes disabled: no light
        np = pulses[0] + pulses[1];
        frame();
        chk_val(32'(pulses[0] + pulses[1]), 32'(np), "disabled pulses");
        $display("test disabled done");
        // strobe 1 every frame, strobe 2 through every selection code
        apb(1'b1, ch_addr(0, OFF_CH_MODE), 32'h1);
        for (int s = 0; s < 4; s++) begin
            apb(1'b1, ch_addr(1, OFF_CH_MODE), 32'h0);
            apb(1'b1, ch_addr(1, OFF_CH_MODE), 32'(1 | (s << MODE_SEL_LO)));
            for (int f = 1; f <= 4; f++) begin
                np = pulses[1];
                frame();
                chk_time(rise_at[0], cyc(pos[0]), 4, "strobe 1 start");
                chk_time(width[0], cyc(dur[0]), 3, "strobe 1 width");
                chk_val(32'(pulses[1] - np), 32'(fires(s, f)), "strobe 2 count");
                if (fires(s, f)) begin
                    chk_time(rise_at[1], cyc(pos[1]), 4, "strobe 2 start");
                    chk_time(width[1], cyc(dur[1]), 3, "strobe 2 width");
                end
                // first frame after enable is odd for both strobes, both dark now
                if (s == 0 && f == 1) rchk(OFF_STATUS, 32'hc, 1'b0);
            end
        end
        $display("test frame selection done");
        // a pulse running past the frame end is cut at the next frame start
        apb(1'b1, ch_addr(0, OFF_CH_POS), 32'h8);
        apb(1'b1, ch_addr(0, OFF_CH_DUR), 32'h5);
        apb(1'b1, ch_addr(1, OFF_CH_MODE), 32'h0);
        np = pulses[1];
        frame();
        frame();
        chk_val(32'(pulses[1] - np), 32'h0, "disabled strobe 2");
        chk_time(width[0], cyc(2), 3, "clipped width");
        $display("test clipping done");
        // trigger strobe on strobe 1 only
        d = 2 + ($random(seed) & 1);
        u = 1 + ($random(seed) & 1);
        apb(1'b1, OFF_CTRL, 32'h1);
        apb(1'b1, OFF_TRG_DELAY, 32'(d));
        apb(1'b1, OFF_TRG_DUR, 32'(u));
        // drop the clipped frame pulse still lit on strobe 1
        apb(1'b1, ch_addr(0, OFF_CH_MODE), 32'h0);
        apb(1'b1, ch_addr(0, OFF_CH_MODE), 32'hf);
        apb(1'b1, ch_addr(1, OFF_CH_MODE), 32'h7);
        np = pulses[1];
        trig();
        chk_time(rise_at[0], cyc(d), CYC_PER_US + 4, "trigger start");
        chk_time(width[0], cyc(u), 3, "trigger width");
        chk_val(32'(pulses[1] - np), 32'h0, "strobe 2 no trigger");
        // out of trigger mode the rise is ignored
        apb(1'b1, OFF_CTRL, 32'h0);
        np = pulses[0];
        trig();
        chk_val(32'(pulses[0] - np), 32'h0, "trigger mode off");
        $display("test trigger done");
        report_and_stop();
    end

    // watchdog against a hang
    initial begin
        repeat (90000) @(posedge CORE_CLK);
        n_errors++;
        $display("Error at %0t: watchdog expired", $time);
        report_and_stop();
    end
endmodule : dual_strobe_pulse_generator_tb
